// >>> bms_top.sv
// Overview of operation
// R1: loader areas low 1KiB, top 2KiB write-protected
// R2: image writes only within 0x400..0x77FF
// R3: app invalid when byte 0x400 is 0xFF
// R4: entry 0x400, vectors from 0x403 step 8
// R5: application jumps to 0x6 for loader
// R6: loader descriptor held at 0x3CC..0x3DD
// R7: serial number 0x3E0..0x3E3, little endian
// R8: serial string descriptor at 0x3E6..0x3FD
// R9: other information bytes read zero
// R10: startup enables pull-downs on indicator lines
// R11: invalid application selects loader mode
// R12: bus power and yellow high select loader
// R13: otherwise run application from entry vector
// R14: application presents CDC ACM identity
// R15: baud 333 line coding enters loader
// R16: let pull-down settle before sampling yellow
module bms_top
	import bms_pkg::*;
#(
	parameter logic [15:0] BMS_VID = 16'h1234, // arbitrary value
	parameter logic [15:0] BMS_PID = 16'h5678  // arbitrary value
) (
	input  wire logic        clk_sys_i,
	input  wire logic        rstn_i,
	input  wire logic        ce_i,
	input  wire logic [7:0]  app_first_byte_i,
	input  wire logic        usb_power_i,
	input  wire logic        yellow_indicator_line_i,
	input  wire logic        cpu_jump_i,
	input  wire logic [15:0] cpu_jump_addr_i,
	input  wire logic        baud_set_i,
	input  wire logic [31:0] baud_rate_i,
	input  wire logic [4:0]  vec_num_i,
	input  wire logic        img_wr_i,
	input  wire logic [15:0] img_addr_i,
	input  wire logic [7:0]  img_data_i,
	input  wire logic [5:0]  info_idx_i,
	input  wire logic [143:0] desc_bytes_i,
	input  wire logic [31:0] serial_i,
	output logic [2:0]       indicator_pd_o,
	output logic [4:0]       port_pull_en_o,
	output logic             decided_o,
	output logic             loader_mode_o,
	output logic             app_run_o,
	output logic [15:0]      entry_addr_o,
	output logic [15:0]      vec_addr_o,
	output logic [7:0]       info_byte_o,
	output logic             prog_en_o,
	output logic [15:0]      prog_addr_o,
	output logic [7:0]       prog_data_o,
	output logic             rec_drop_o,
	output logic [15:0]      usb_vid_o,
	output logic [15:0]      usb_pid_o
);
	bms_state_t state;
	logic [2:0] yel_sync;
	logic       yel_stable;
	logic [7:0] settle_cnt;
	logic [15:0] info_addr;
	logic [3:0]  hex_nib;
	logic [15:0] sstr_off;
	logic [2:0]  dig_pos;
	bms_wr_if    wr_bus ();

	// yellow pin crosses in: three stages, change accepted when 2nd and 3rd agree
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			yel_sync   <= 3'h0;
			yel_stable <= 1'b0;
		end else if (ce_i) begin
			yel_sync <= {yel_sync[1:0], yellow_indicator_line_i};
			if (yel_sync[1] == yel_sync[2]) begin
				yel_stable <= yel_sync[2];
			end
		end
	end

	// startup sequence; runs after every reset
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state      <= BMS_ST_PULL;
			settle_cnt <= 8'h00;
		end else if (ce_i) begin
			case (state)
				BMS_ST_PULL: begin
					settle_cnt <= 8'h00;
					state      <= BMS_ST_SETTLE; // R10
				end
				BMS_ST_SETTLE: begin
					// pull-down plus synchroniser latency before trusting the line
					settle_cnt <= settle_cnt + 8'h01;
					if (settle_cnt == 8'(BMS_SETTLE_CYC + 3)) begin
						state <= BMS_ST_VALID; // R16
					end
				end
				BMS_ST_VALID: begin
					if (app_first_byte_i == BMS_BLANK_BYTE) begin
						state <= BMS_ST_LOADER; // R3 R11
					end else begin
						state <= BMS_ST_SENSE;
					end
				end
				BMS_ST_SENSE: begin
					if (usb_power_i && yel_stable) begin
						state <= BMS_ST_LOADER; // R12
					end else begin
						state <= BMS_ST_APP; // R13
					end
				end
				BMS_ST_APP: begin
					// application may hand control back at any time
					if (cpu_jump_i && cpu_jump_addr_i == BMS_JUMP_LOADER) begin
						state <= BMS_ST_LOADER; // R5
					end else if (baud_set_i && baud_rate_i == BMS_LOADER_BAUD) begin
						state <= BMS_ST_LOADER; // R15
					end
				end
				BMS_ST_LOADER: state <= BMS_ST_LOADER;
				default: state <= BMS_ST_PULL;
			endcase
		end
	end

	// pull setup held from reset: indicators pulled down, rest of port floating
	assign indicator_pd_o = 3'h7; // R10
	assign port_pull_en_o = 5'h00; // R10
	assign decided_o      = (state == BMS_ST_LOADER) || (state == BMS_ST_APP);
	assign loader_mode_o  = (state == BMS_ST_LOADER);
	assign app_run_o      = (state == BMS_ST_APP);
	assign usb_vid_o      = BMS_VID; // R14
	assign usb_pid_o      = BMS_PID; // R14

	// vector remap registered so the fetch path sees a stable address
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			entry_addr_o <= BMS_ENTRY_ADDR;
			vec_addr_o   <= BMS_VEC0_ADDR;
		end else if (ce_i) begin
			entry_addr_o <= BMS_ENTRY_ADDR; // R4
			vec_addr_o   <= BMS_VEC0_ADDR + (16'(vec_num_i) << 3); // R4
		end
	end

	function automatic logic [7:0] hex_char(input logic [3:0] n);
		return (n < 4'hA) ? (8'h30 + 8'(n)) : (8'h37 + 8'(n));
	endfunction : hex_char

	// information block byte; string descriptor is 8 hex digits in UTF-16LE
	assign info_addr = BMS_INFO_LO + 16'(info_idx_i);
	// digit position wraps inside 0..7, so the nibble select never leaves the serial word
	assign sstr_off  = info_addr - BMS_SSTR_LO - 16'h0002;
	assign dig_pos   = 3'h7 - 3'(sstr_off >> 1);
	assign hex_nib   = serial_i[{dig_pos, 2'b00} +: 4];
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			info_byte_o <= 8'h00;
		end else if (ce_i) begin
			if (info_addr >= BMS_DESC_LO && info_addr <= BMS_DESC_HI) begin
				info_byte_o <= desc_bytes_i[8 * (info_addr - BMS_DESC_LO) +: 8]; // R6
			end else if (info_addr >= BMS_SER_LO && info_addr <= BMS_SER_HI) begin
				info_byte_o <= serial_i[8 * (info_addr - BMS_SER_LO) +: 8]; // R7
			end else if (info_addr == BMS_SSTR_LO) begin
				info_byte_o <= 8'(BMS_SSTR_HI - BMS_SSTR_LO + 16'h0001); // R8
			end else if (info_addr == BMS_SSTR_LO + 16'h0001) begin
				info_byte_o <= 8'h03; // R8
			end else if (info_addr > BMS_SSTR_LO + 16'h0001 && info_addr <= BMS_SSTR_LO + 16'h0011) begin
				info_byte_o <= info_addr[0] ? 8'h00 : hex_char(hex_nib); // R8
			end else if (info_addr > BMS_SSTR_LO + 16'h0011 && info_addr <= BMS_SSTR_HI) begin
				// padding after the eighth digit keeps the advertised length
				info_byte_o <= 8'h00; // R8
			end else begin
				info_byte_o <= 8'h00; // R9
			end
		end
	end

	assign wr_bus.req  = img_wr_i && (state == BMS_ST_LOADER);
	assign wr_bus.addr = img_addr_i;
	assign wr_bus.data = img_data_i;

	bms_wr_filter u_filter (
		.clk_sys_i   (clk_sys_i),
		.rstn_i      (rstn_i),
		.ce_i        (ce_i),
		.wr          (wr_bus),
		.prog_en_o   (prog_en_o),
		.prog_addr_o (prog_addr_o),
		.prog_data_o (prog_data_o),
		.rec_drop_o  (rec_drop_o)
	);

	AST_BLANK_NO_APP: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		(ce_i && state == BMS_ST_VALID && app_first_byte_i == BMS_BLANK_BYTE) |=> loader_mode_o) // R3
		else $error("blank application not sent to loader");
	AST_SENSE_LOADER: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		(ce_i && state == BMS_ST_SENSE && usb_power_i && yel_stable) |=> loader_mode_o) // R12
		else $error("button sense ignored");
	AST_RUN_APP: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		(ce_i && state == BMS_ST_SENSE && !(usb_power_i && yel_stable)) |=> app_run_o) // R13
		else $error("application not started");
	AST_BAUD: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		(ce_i && app_run_o && baud_set_i && baud_rate_i == BMS_LOADER_BAUD) |=> loader_mode_o) // R15
		else $error("baud request ignored");
	AST_JUMP: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		(ce_i && app_run_o && cpu_jump_i && cpu_jump_addr_i == BMS_JUMP_LOADER) |=> loader_mode_o) // R5
		else $error("jump to loader ignored");
	AST_VEC: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		ce_i |=> vec_addr_o == BMS_VEC0_ADDR + 16'($past(vec_num_i)) * BMS_VEC_STEP) // R4
		else $error("vector remap wrong");
	AST_SETTLE: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		(state == BMS_ST_SENSE) |-> (settle_cnt >= 8'(BMS_SETTLE_CYC))) // R16
		else $error("yellow sampled before settling");
	AST_ZERO_INFO: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		(ce_i && (info_addr == 16'h03DE || info_addr == 16'h03FE)) |=> info_byte_o == 8'h00) // R9
		else $error("reserved info byte not zero");

	// low side of the window and the mode gate, as seen from the filter's verdict
	AST_DROP_LOW: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		(ce_i && wr_bus.req && !wr_bus.ok) |=> (rec_drop_o && !prog_en_o)) // R2
		else $error("write outside window not dropped");
	AST_NO_WR_APP: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		(ce_i && img_wr_i && !loader_mode_o) |=> (!prog_en_o && !rec_drop_o)) // R2
		else $error("image write acted on outside loader mode");
endmodule : bms_top

// >>> bms_pkg.sv
package bms_pkg;
	localparam logic [15:0] BMS_APP_LO      = 16'h0400;
	localparam logic [15:0] BMS_APP_HI      = 16'h77FF;
	localparam logic [15:0] BMS_FLASH_TOP   = 16'h7FFF;
	localparam logic [15:0] BMS_ENTRY_ADDR  = 16'h0400;
	localparam logic [15:0] BMS_VEC0_ADDR   = 16'h0403;
	localparam logic [15:0] BMS_VEC_STEP    = 16'h0008;
	localparam logic [15:0] BMS_JUMP_LOADER = 16'h0006;
	localparam logic [7:0]  BMS_BLANK_BYTE  = 8'hFF;
	localparam logic [15:0] BMS_INFO_LO     = 16'h03CC;
	localparam logic [15:0] BMS_INFO_HI     = 16'h03FF;
	localparam logic [15:0] BMS_DESC_LO     = 16'h03CC;
	localparam logic [15:0] BMS_DESC_HI     = 16'h03DD;
	localparam logic [15:0] BMS_SER_LO      = 16'h03E0;
	localparam logic [15:0] BMS_SER_HI      = 16'h03E3;
	localparam logic [15:0] BMS_SSTR_LO     = 16'h03E6;
	localparam logic [15:0] BMS_SSTR_HI     = 16'h03FD;
	localparam logic [31:0] BMS_LOADER_BAUD = 32'h0000014D;
	localparam int          BMS_CLK_HZ      = 20000000;
	localparam int          BMS_SETTLE_NS   = 1000;
	localparam int          BMS_SETTLE_CYC  = (BMS_SETTLE_NS * (BMS_CLK_HZ / 1000000) + 999) / 1000;
	localparam int          BMS_INFO_BYTES  = 52;

	typedef enum logic [2:0] {BMS_ST_PULL, BMS_ST_SETTLE, BMS_ST_VALID, BMS_ST_SENSE,
		BMS_ST_LOADER, BMS_ST_APP} bms_state_t;
endpackage : bms_pkg

// >>> bms_wr_if.sv
interface bms_wr_if;
	logic        req;
	logic [15:0] addr;
	logic [7:0]  data;
	logic        ok;
	modport src (output req, output addr, output data, input ok);
	modport flt (input req, input addr, input data, output ok);
endinterface : bms_wr_if

// >>> bms_wr_filter.sv
module bms_wr_filter
	import bms_pkg::*;
(
	input  wire logic clk_sys_i,
	input  wire logic rstn_i,
	input  wire logic ce_i,
	bms_wr_if.flt     wr,
	output logic      prog_en_o,
	output logic [15:0] prog_addr_o,
	output logic [7:0]  prog_data_o,
	output logic      rec_drop_o
);
	// each byte is judged on its own address against the application window
	function automatic logic in_app(input logic [15:0] a);
		return (a >= BMS_APP_LO) && (a <= BMS_APP_HI);
	endfunction : in_app

	assign wr.ok = in_app(wr.addr);

	// loader areas are never written: protects low 1 KiB and top 2 KiB
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			prog_en_o   <= 1'b0;
			prog_addr_o <= 16'h0000;
			prog_data_o <= 8'h00;
			rec_drop_o  <= 1'b0;
		end else if (ce_i) begin
			prog_en_o   <= wr.req && in_app(wr.addr); // R1 R2
			rec_drop_o  <= wr.req && !in_app(wr.addr); // R2
			prog_addr_o <= wr.addr;
			prog_data_o <= wr.data;
		end
	end

	AST_NO_LOADER_WRITE: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		prog_en_o |-> (prog_addr_o >= BMS_APP_LO && prog_addr_o <= BMS_APP_HI)) // R1
		else $error("write reached loader area");
	AST_DROP_OUT: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		(ce_i && wr.req && wr.addr > BMS_APP_HI) |=> (rec_drop_o && !prog_en_o)) // R2
		else $error("out of range write not dropped");
endmodule : bms_wr_filter

// >>> bms_host_model.sv
module bms_host_model (
	input  wire logic        clk_sys_i,
	output logic             baud_set_o,
	output logic [31:0]      baud_rate_o
);
	timeunit 1ns;
	timeprecision 1ps;

	// idle host, ordinary line coding
	initial begin
		baud_set_o  = 1'b0;
		baud_rate_o = 32'h00002580;
	end

	// one line-coding command, launched off the falling edge
	task automatic send_baud(input logic [31:0] rate);
		@(negedge clk_sys_i);
		baud_set_o  <= 1'b1;
		baud_rate_o <= rate;
		@(negedge clk_sys_i);
		baud_set_o  <= 1'b0;
		baud_rate_o <= ~rate; // stale rate must not look valid
	endtask : send_baud
endmodule : bms_host_model

// >>> bms_top_tb_top.sv
module bms_top_tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	// arbitrary identity values, only checked for pass-through
	localparam logic [15:0]  VID  = 16'hA5C3;
	localparam logic [15:0]  PID  = 16'h3C5A;
	localparam logic [143:0] DESC = {9{16'hC1D2}};
	localparam logic [31:0]  SER  = 32'h89ABCDEF;
	logic        clk = 1'b0, rstn = 1'b0, ubp = 1'b0, ylw = 1'b0, jmp = 1'b0, wr = 1'b0, ce = 1'b1;
	logic [7:0]  fbyte = 8'hFF, wdata = 8'h00, info, pdata;
	logic [15:0] jaddr = 16'h0000, waddr = 16'h0000, entry, vec, paddr, vid, pid;
	logic [4:0]  vnum = 5'h00, pull;
	logic [5:0]  idx = 6'h00;
	logic [2:0]  pd;
	logic        dec, ldr, run, pen, drop, bset;
	logic [31:0] brate;
	int          miscompares = 0, n_checks = 0;

	// 20 MHz system clock
	always #25 clk = ~clk;

	bms_host_model i_host (.clk_sys_i(clk), .baud_set_o(bset), .baud_rate_o(brate));

	bms_top #(.BMS_VID(VID), .BMS_PID(PID)) i_dut (
		.clk_sys_i(clk), .rstn_i(rstn), .ce_i(ce), .app_first_byte_i(fbyte),
		.usb_power_i(ubp), .yellow_indicator_line_i(ylw), .cpu_jump_i(jmp),
		.cpu_jump_addr_i(jaddr), .baud_set_i(bset), .baud_rate_i(brate), .vec_num_i(vnum),
		.img_wr_i(wr), .img_addr_i(waddr), .img_data_i(wdata), .info_idx_i(idx),
		.desc_bytes_i(DESC), .serial_i(SER), .indicator_pd_o(pd), .port_pull_en_o(pull),
		.decided_o(dec), .loader_mode_o(ldr), .app_run_o(run), .entry_addr_o(entry),
		.vec_addr_o(vec), .info_byte_o(info), .prog_en_o(pen), .prog_addr_o(paddr),
		.prog_data_o(pdata), .rec_drop_o(drop), .usb_vid_o(vid), .usb_pid_o(pid));

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	task automatic test_done;
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : test_done

	// reset, then wait for the boot decision under a bound
	task automatic boot(input logic [7:0] fb, input logic up, input logic yl);
		int n;
		rstn = 1'b0;
		fbyte = fb;
		ubp = up;
		ylw = yl;
		repeat (3) @(negedge clk);
		rstn = 1'b1;
		n = 0;
		while (dec !== 1'b1 && n < 60) begin
			@(negedge clk);
			n++;
		end
		if (n == 60) begin
			miscompares++;
			test_done();
		end
		chk("settle", 1'b1, n > 20);
		chk("pulls", 8'h07, {pull, pd});
	endtask : boot

	// write strobe held high across calls, so bytes go back to back
	task automatic wbyte(input logic [15:0] a, input logic ok);
		wr = 1'b1;
		waddr = a;
		wdata = ~a[7:0];
		@(negedge clk);
		chk("prog_drop", {ok, ~ok}, {pen, drop});
		if (ok) chk("prog_word", {a, ~a[7:0]}, {paddr, pdata});
	endtask : wbyte

	task automatic jump(input logic [15:0] a);
		jmp = 1'b1;
		jaddr = a;
		@(negedge clk);
		jmp = 1'b0;
		jaddr = ~a;
		repeat (2) @(negedge clk);
	endtask : jump

	task automatic rd(input logic [5:0] i, input logic [7:0] e);
		idx = i;
		@(negedge clk);
		chk("info", e, info);
	endtask : rd

	task automatic t_blank;
		boot(8'hFF, 1'b0, 1'b0);
		chk("mode", 2'b10, {ldr, run});
		chk("ids", {VID, PID}, {vid, pid});
		wbyte(16'h03FF, 1'b0);
		wbyte(16'h0400, 1'b1);
		wbyte(16'h77FF, 1'b1);
		wbyte(16'h7800, 1'b0);
		wbyte(16'h0000, 1'b0);
		wbyte(16'h7FFF, 1'b0);
		wr = 1'b0;
		$display("blank image test done");
	endtask : t_blank

	task automatic t_power;
		boot(8'h02, 1'b1, 1'b1);
		chk("mode", 2'b10, {ldr, run});
		boot(8'h02, 1'b0, 1'b1);
		chk("mode", 2'b01, {ldr, run});
		$display("power sense test done");
	endtask : t_power

	task automatic t_app;
		boot(8'h02, 1'b1, 1'b0);
		chk("mode", 2'b01, {ldr, run});
		chk("entry", 16'h0400, entry);
		vnum = 5'h1F;
		@(negedge clk);
		chk("vector", 16'h04FB, vec);
		// clock enable low must freeze the remap register
		ce = 1'b0;
		vnum = 5'h00;
		@(negedge clk);
		chk("vector", 16'h04FB, vec);
		ce = 1'b1;
		@(negedge clk);
		chk("vector", 16'h0403, vec);
		// image writes outside loader mode are ignored entirely
		wr = 1'b1;
		waddr = 16'h0400;
		@(negedge clk);
		chk("prog_drop", 2'b00, {pen, drop});
		wr = 1'b0;
		rd(6'h00, DESC[7:0]);
		rd(6'h11, DESC[143:136]);
		rd(6'h14, SER[7:0]);
		rd(6'h17, SER[31:24]);
		rd(6'h1A, 8'h18);
		rd(6'h1B, 8'h03);
		rd(6'h1C, 8'h38);
		rd(6'h1D, 8'h00);
		rd(6'h2A, 8'h46);
		rd(6'h2C, 8'h00);
		rd(6'h12, 8'h00);
		rd(6'h18, 8'h00);
		rd(6'h33, 8'h00);
		jump(16'h0007);
		chk("mode", 2'b01, {ldr, run});
		jump(16'h0006);
		chk("mode", 2'b10, {ldr, run});
		$display("application test done");
	endtask : t_app

	task automatic t_baud;
		boot(8'h02, 1'b0, 1'b0);
		i_host.send_baud(32'h0000014C);
		repeat (2) @(negedge clk);
		chk("mode", 2'b01, {ldr, run});
		i_host.send_baud(32'h0000014D);
		repeat (2) @(negedge clk);
		chk("mode", 2'b10, {ldr, run});
		$display("baud request test done");
	endtask : t_baud

	// main sequence
	initial begin
		@(negedge clk);
		t_blank();
		t_power();
		t_app();
		t_baud();
		test_done();
	end
endmodule : bms_top_tb_top
